// [pss_pkg.sv]
// Package for the parallel slave buffer status block.
// Assumes a 32-bit AXI4-Lite register bus and a single 10 MHz clock.
package pss_pkg;
  localparam int unsigned  NSLOT         = 4;
  localparam logic [3:0]   ADDR_STATUS   = 4'h0;
  localparam logic [3:0]   ADDR_IRQ_STAT = 4'h4;
  localparam logic [3:0]   ADDR_IRQ_MASK = 4'h8;
  localparam logic [3:0]   ADDR_IN_DATA  = 4'hC;
  localparam int unsigned  ADDR_W        = 4;
  localparam int unsigned  BIT_IN_ALL    = 15;
  localparam int unsigned  BIT_IN_OVF    = 14;
  localparam int unsigned  BIT_IN_SLOT   = 8;
  localparam int unsigned  BIT_OUT_ALL   = 7;
  localparam int unsigned  BIT_OUT_UNF   = 6;
  localparam int unsigned  BIT_OUT_SLOT  = 0;
  localparam logic [15:0]  STATUS_RESET  = 16'h008F;
  localparam logic [1:0]   IRQ_OVF       = 2'h1;
  localparam logic [1:0]   IRQ_UNF       = 2'h2;
  localparam logic [1:0]   RESP_OKAY     = 2'h0;
  localparam logic [1:0]   RESP_SLVERR   = 2'h2;
  typedef enum logic [1:0] {PSS_IDLE, PSS_RESP} pss_wr_state_t;
endpackage : pss_pkg

// [pss_slot.sv]
// One byte slot with a full flag, filled from one side and drained from the other.
// Assumes fill and drain strobes are single-cycle and synchronous to aclk.
`timescale 1ns/1ns
module pss_slot
  import pss_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic       fill,
  input  wire logic [7:0] fill_data,
  input  wire logic       drain,
  output logic            full_q,
  output logic [7:0]      data_q
);
  // A fill in the same cycle as a drain wins, so the fresh byte is never lost.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      full_q <= 1'b0;
      data_q <= 8'h00;
    end
    else if (ce)
    begin
      if (fill)
      begin
        full_q <= 1'b1;
        data_q <= fill_data;
      end
      else if (drain)
      begin
        full_q <= 1'b0;
      end
    end
  end
endmodule : pss_slot

// [pss_sticky.sv]
// Sticky error flag set by hardware, cleared by a software write of zero.
// Assumes set and clear are single-cycle strobes.
`timescale 1ns/1ns
module pss_sticky
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag_q
);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flag_q <= 1'b0;
    end
    else if (ce)
    begin
      if (set)
      begin
        flag_q <= 1'b1;
      end
      else if (clr)
      begin
        flag_q <= 1'b0;
      end
    end
  end
endmodule : pss_sticky

// [pss_top.sv]
// Parallel slave port buffer and status flags, with AXI4-Lite registers.
// Assumes host strobes are synchronous one-cycle pulses on aclk.
`timescale 1ns/1ns
module pss_top
  import pss_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic              host_wr,
  input  wire logic [1:0]        host_wr_sel,
  input  wire logic [7:0]        host_wr_data,
  input  wire logic              host_rd,
  input  wire logic [1:0]        host_rd_sel,
  output logic [7:0]             host_rd_data_q,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   irq_q
);
  import pss_pkg::*;

  function automatic logic [NSLOT-1:0] sel_dec(input logic [1:0] sel);
    sel_dec = NSLOT'(1) << sel;
  endfunction : sel_dec

  logic [NSLOT-1:0] in_full;
  logic [NSLOT-1:0] out_full;
  logic [7:0]       in_byte [NSLOT];
  logic [7:0]       out_byte [NSLOT];
  logic [NSLOT-1:0] in_fill;
  logic [NSLOT-1:0] in_drain;
  logic [NSLOT-1:0] out_fill;
  logic [NSLOT-1:0] out_drain;
  logic             ovf_set;
  logic             unf_set;
  logic             ovf_clr;
  logic             unf_clr;
  logic             ovf_q;
  logic             unf_q;
  logic [15:0]      status;
  logic [1:0]       irq_stat_q;
  logic [1:0]       irq_mask_q;
  logic             aw_held_q;
  logic             w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]      wdata_q;
  logic [3:0]       wstrb_q;
  logic             wr_go;
  logic             rd_go;
  pss_wr_state_t    wr_state_q;

  // Host strobes into each slot.
  always_comb
  begin
    in_fill   = host_wr ? sel_dec(host_wr_sel) : '0;
    out_drain = host_rd ? sel_dec(host_rd_sel) : '0;
  end

  assign ovf_set = host_wr && in_full[host_wr_sel];
  assign unf_set = host_rd && !out_full[host_rd_sel];

  // Output slot n lives at byte address ADDR_IN_DATA, word lane n; input slots read from the same word.
  assign wr_go = aw_held_q && w_held_q && (wr_state_q == PSS_IDLE);
  assign rd_go = s_axi_arvalid && s_axi_arready;

  generate
    for (genvar i = 0; i < NSLOT; i++)
    begin : g_slot
      assign out_fill[i] = wr_go && (awaddr_q == ADDR_IN_DATA) && wstrb_q[i];
      assign in_drain[i] = rd_go && (s_axi_araddr == ADDR_IN_DATA);
      pss_slot u_in (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ce        (ce),
        .fill      (in_fill[i]),
        .fill_data (host_wr_data),
        .drain     (in_drain[i]),
        .full_q    (in_full[i]),
        .data_q    (in_byte[i])
      );
      pss_slot u_out (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ce        (ce),
        .fill      (out_fill[i]),
        .fill_data (wdata_q[8*i +: 8]),
        .drain     (out_drain[i]),
        .full_q    (out_full[i]),
        .data_q    (out_byte[i])
      );
    end
  endgenerate

  // Software clears a sticky flag by writing zero to its bit in the low status byte lanes.
  assign ovf_clr = wr_go && (awaddr_q == ADDR_STATUS) && wstrb_q[1] && !wdata_q[BIT_IN_OVF];
  assign unf_clr = wr_go && (awaddr_q == ADDR_STATUS) && wstrb_q[0] && !wdata_q[BIT_OUT_UNF];

  pss_sticky u_ovf (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .set     (ovf_set),
    .clr     (ovf_clr),
    .flag_q  (ovf_q)
  );
  pss_sticky u_unf (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .set     (unf_set),
    .clr     (unf_clr),
    .flag_q  (unf_q)
  );

  always_comb
  begin
    status = '0;
    status[BIT_IN_ALL]                 = &in_full;
    status[BIT_IN_OVF]                 = ovf_q;
    status[BIT_IN_SLOT +: NSLOT]       = in_full;
    status[BIT_OUT_ALL]                = ~|out_full;
    status[BIT_OUT_UNF]                = unf_q;
    status[BIT_OUT_SLOT +: NSLOT]      = ~out_full;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      host_rd_data_q <= 8'h00;
    end
    else if (ce && host_rd)
    begin
      host_rd_data_q <= out_byte[host_rd_sel];
    end
  end

  // Interrupt status: set wins over a write-one clear.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat_q <= 2'h0;
      irq_mask_q <= 2'h0;
      irq_q      <= 1'b0;
    end
    else if (ce)
    begin
      irq_stat_q <= (irq_stat_q & ~((wr_go && awaddr_q == ADDR_IRQ_STAT && wstrb_q[0]) ? wdata_q[1:0] : 2'h0))
                    | (ovf_set ? IRQ_OVF : 2'h0) | (unf_set ? IRQ_UNF : 2'h0);
      if (wr_go && awaddr_q == ADDR_IRQ_MASK && wstrb_q[0])
      begin
        irq_mask_q <= wdata_q[1:0];
      end
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Write channel: address and data taken in either order, then one response.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      wr_state_q    <= PSS_IDLE;
    end
    else if (ce)
    begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      unique case (wr_state_q)
        PSS_IDLE:
        begin
          if (wr_go)
          begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_q == ADDR_STATUS || awaddr_q == ADDR_IRQ_STAT ||
                             awaddr_q == ADDR_IRQ_MASK || awaddr_q == ADDR_IN_DATA) ? RESP_OKAY : RESP_SLVERR;
            wr_state_q   <= PSS_RESP;
          end
        end
        PSS_RESP:
        begin
          if (s_axi_bready)
          begin
            s_axi_bvalid <= 1'b0;
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            wr_state_q   <= PSS_IDLE;
          end
        end
        default:
        begin
          wr_state_q <= PSS_IDLE;
        end
      endcase
    end
  end

  // Read channel: one read at a time, answer the cycle after the address is taken.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_arready <= !s_axi_rvalid && !rd_go;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        unique case (s_axi_araddr)
          ADDR_STATUS:   s_axi_rdata <= {16'h0000, status};
          ADDR_IRQ_STAT: s_axi_rdata <= {30'h0000_0000, irq_stat_q};
          ADDR_IRQ_MASK: s_axi_rdata <= {30'h0000_0000, irq_mask_q};
          ADDR_IN_DATA:  s_axi_rdata <= {in_byte[3], in_byte[2], in_byte[1], in_byte[0]};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  property p_ovf_set;
    @(posedge aclk) disable iff (!aresetn) ce && ovf_set |=> ovf_q && irq_stat_q[0];
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged");
  property p_unf_set;
    @(posedge aclk) disable iff (!aresetn) ce && unf_set |=> unf_q;
  endproperty
  a_unf_set: assert property (p_unf_set) else $error("underflow not flagged");
  property p_in_full;
    @(posedge aclk) disable iff (!aresetn) ce && host_wr |=> in_full[$past(host_wr_sel)];
  endproperty
  a_in_full: assert property (p_in_full) else $error("input slot not full after write");
  property p_in_drain;
    @(posedge aclk) disable iff (!aresetn) ce && rd_go && s_axi_araddr == ADDR_IN_DATA && !host_wr |=> in_full == 4'h0;
  endproperty
  a_in_drain: assert property (p_in_drain) else $error("input full not cleared by read");
  // Checked on the bus image, so a wrong lane or a wrong aggregate on the read path both show up.
  property p_out_all;
    @(posedge aclk) disable iff (!aresetn) s_axi_rvalid && $past(rd_go) && $past(s_axi_araddr) == ADDR_STATUS
      |-> s_axi_rdata[BIT_OUT_ALL] == (s_axi_rdata[BIT_OUT_SLOT +: NSLOT] == 4'hF);
  endproperty
  a_out_all: assert property (p_out_all) else $error("output all-empty wrong");
  property p_out_fill;
    @(posedge aclk) disable iff (!aresetn) ce && out_fill[0] |=> !status[BIT_OUT_SLOT];
  endproperty
  a_out_fill: assert property (p_out_fill) else $error("output slot empty after write");
  property p_resvd;
    @(posedge aclk) disable iff (!aresetn) s_axi_rvalid && $past(s_axi_araddr) == ADDR_STATUS && $past(rd_go)
      |-> s_axi_rdata[13:12] == 2'h0 && s_axi_rdata[5:4] == 2'h0;
  endproperty
  a_resvd: assert property (p_resvd) else $error("reserved status bits nonzero");
  property p_in_all;
    @(posedge aclk) disable iff (!aresetn) s_axi_rvalid && $past(rd_go) && $past(s_axi_araddr) == ADDR_STATUS
      |-> s_axi_rdata[BIT_IN_ALL] == (s_axi_rdata[BIT_IN_SLOT +: NSLOT] == 4'hF);
  endproperty
  a_in_all: assert property (p_in_all) else $error("input all-full wrong");
  c_ovf: cover property (@(posedge aclk) ovf_q && ovf_clr);
  c_unf: cover property (@(posedge aclk) unf_set);
  c_full: cover property (@(posedge aclk) &in_full);
endmodule : pss_top

// [pss_host_model.sv]
// Model of the external host that writes input slots and reads output slots.
// Assumes the bench calls its tasks; strobes are one-cycle pulses on aclk.
`timescale 1ns/1ns
module pss_host_model
(
  input  wire logic       aclk,
  output logic            host_wr,
  output logic [1:0]      host_wr_sel,
  output logic [7:0]      host_wr_data,
  output logic            host_rd,
  output logic [1:0]      host_rd_sel,
  input  wire logic [7:0] host_rd_data_q
);
  initial
  begin
    host_wr      = 1'b0;
    host_wr_sel  = 2'h0;
    host_wr_data = 8'h00;
    host_rd      = 1'b0;
    host_rd_sel  = 2'h0;
  end

  // The data lines are inverted after use so that a stale byte is never mistaken for a fresh one.
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(posedge aclk);
    host_wr      <= 1'b1;
    host_wr_sel  <= s;
    host_wr_data <= d;
    @(posedge aclk);
    host_wr      <= 1'b0;
    host_wr_sel  <= ~s;
    host_wr_data <= ~d;
  endtask : wr

  task automatic rd(input logic [1:0] s, output logic [7:0] d);
    @(posedge aclk);
    host_rd     <= 1'b1;
    host_rd_sel <= s;
    @(posedge aclk);
    host_rd     <= 1'b0;
    host_rd_sel <= ~s;
    @(posedge aclk);
    d = host_rd_data_q;
  endtask : rd
endmodule : pss_host_model

// [pss_top_tb.sv]
// Self-checking bench for the parallel slave buffer status block.
// Assumes the host model and an AXI4-Lite master built from tasks here.
`timescale 1ns/1ns
module pss_top_tb;
  import pss_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic hw, hr;
  logic [1:0] hws, hrs, bresp, rresp;
  logic [7:0] hwd, hrd, b;
  logic [3:0] awaddr = '0, araddr = '0, wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq_q;
  logic [31:0] wdata = '0, rdata, v;
  logic [1:0] r;
  int err_total = 0;
  int comparisons = 0;

  always #50 aclk = ~aclk;

  pss_host_model host (.aclk(aclk), .host_wr(hw), .host_wr_sel(hws), .host_wr_data(hwd),
    .host_rd(hr), .host_rd_sel(hrs), .host_rd_data_q(hrd));

  pss_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .host_wr(hw), .host_wr_sel(hws),
    .host_wr_data(hwd), .host_rd(hr), .host_rd_sel(hrs), .host_rd_data_q(hrd),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq_q(irq_q));

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : cmp

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    axi_rd(a);
    cmp("read data", e, v);
    cmp("read resp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask : rd_chk

  task automatic wr_chk(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    axi_wr(a, d, s);
    cmp("write resp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask : wr_chk

  task automatic irq_chk(input logic e);
    repeat (3) @(posedge aclk);
    cmp("irq", {31'h0, e}, {31'h0, irq_q});
  endtask : irq_chk

  task automatic t_reset;
    rd_chk(ADDR_STATUS, {16'h0, STATUS_RESET});
    irq_chk(1'b0);
  endtask : t_reset

  task automatic t_input;
    for (int i = 0; i < 4; i++)
    begin
      if (i == 3) rd_chk(ADDR_STATUS, 32'h0000_078F);
      host.wr(2'(i), 8'(8'h11 * (i + 1)));
    end
    rd_chk(ADDR_STATUS, 32'h0000_8F8F);
    rd_chk(ADDR_IN_DATA, 32'h4433_2211);
    rd_chk(ADDR_STATUS, 32'h0000_008F);
    host.wr(2'h0, 8'h55);
    host.wr(2'h0, 8'h66);
    rd_chk(ADDR_STATUS, 32'h0000_418F);
    axi_rd(ADDR_IN_DATA);
    rd_chk(ADDR_STATUS, 32'h0000_408F);
    rd_chk(ADDR_IRQ_STAT, {30'h0, IRQ_OVF});
    irq_chk(1'b0);
    wr_chk(ADDR_IRQ_MASK, {30'h0, IRQ_OVF}, 4'b0001);
    irq_chk(1'b1);
    wr_chk(ADDR_IRQ_STAT, {30'h0, IRQ_OVF}, 4'b0001);
    irq_chk(1'b0);
    wr_chk(ADDR_STATUS, 32'h0000_3000, 4'b0010);
    rd_chk(ADDR_STATUS, 32'h0000_008F);
  endtask : t_input

  task automatic t_output;
    wr_chk(ADDR_IN_DATA, 32'h0000_B2A1, 4'b0011);
    rd_chk(ADDR_STATUS, 32'h0000_000C);
    host.rd(2'h0, b);
    cmp("host byte", 32'h0000_00A1, {24'h0, b});
    rd_chk(ADDR_STATUS, 32'h0000_000D);
    host.rd(2'h1, b);
    cmp("host byte", 32'h0000_00B2, {24'h0, b});
    rd_chk(ADDR_STATUS, 32'h0000_008F);
    host.rd(2'h2, b);
    rd_chk(ADDR_STATUS, 32'h0000_00CF);
    rd_chk(ADDR_IRQ_STAT, {30'h0, IRQ_UNF});
    wr_chk(ADDR_IRQ_MASK, {30'h0, IRQ_UNF}, 4'b0001);
    irq_chk(1'b1);
    wr_chk(ADDR_IRQ_STAT, {30'h0, IRQ_UNF}, 4'b0001);
    irq_chk(1'b0);
    wr_chk(ADDR_STATUS, 32'h0000_0000, 4'b0001);
    rd_chk(ADDR_STATUS, 32'h0000_008F);
  endtask : t_output

  task automatic t_unmapped;
    axi_rd(4'h2);
    cmp("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    cmp("unmapped data", 32'h0000_0000, v);
    axi_wr(4'h6, 32'hFFFF_FFFF, 4'b1111);
    cmp("unmapped wresp", {30'h0, RESP_SLVERR}, {30'h0, r});
  endtask : t_unmapped

  // A host write while the clock enable is low must leave every flag untouched.
  task automatic t_freeze;
    @(posedge aclk);
    ce <= 1'b0;
    host.wr(2'h1, 8'h77);
    @(posedge aclk);
    ce <= 1'b1;
    rd_chk(ADDR_STATUS, 32'h0000_008F);
  endtask : t_freeze

  // A reset in mid-run must wipe a full slot, a sticky flag and the interrupt status.
  task automatic t_rst_mid;
    host.wr(2'h2, 8'h5A);
    host.wr(2'h2, 8'hA5);
    rd_chk(ADDR_STATUS, 32'h0000_448F);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(ADDR_STATUS, {16'h0, STATUS_RESET});
    rd_chk(ADDR_IRQ_STAT, 32'h0000_0000);
  endtask : t_rst_mid

  task automatic end_sim;
    $display("checks %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // The whole run needs a few hundred cycles; this leaves a wide margin.
  initial
  begin
    #(3000 * 100);
    err_total++;
    end_sim();
  end

  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_input();
    t_output();
    t_unmapped();
    t_freeze();
    t_rst_mid();
    end_sim();
  end
endmodule : pss_top_tb
